// file: src/lvdss_pkg.sv
package lvdss_pkg;

    // link geometry
    localparam int unsigned LANES = 3;
    localparam int unsigned SLICE_W = 7;
    localparam int unsigned DATA_W = LANES * SLICE_W;
    localparam int unsigned FIFO_DEPTH = 16;

    // pin synchroniser depth and the two stages compared
    localparam int unsigned SYNC_STAGES = 3;
    localparam int unsigned SYNC_MID = 1;
    localparam int unsigned SYNC_LAST = 2;

    // serial slot positions within one pixel period
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h6;

    // forwarded clock level per slot, rising at slot 0
    localparam logic [6:0] FCLK_PATTERN = 7'h0F;

    // pixel clock range the controller must keep
    localparam int unsigned PCLK_MIN_MHZ = 31;
    localparam int unsigned PCLK_MAX_MHZ = 68;

    typedef logic [DATA_W-1:0] lvdss_word_type;
    typedef logic [SLICE_W-1:0] lvdss_slice_type;
    typedef logic [2:0] lvdss_slot_type;

    // state of the system clock domain
    typedef struct packed {
        logic [SYNC_STAGES-1:0] pclk_sync;
        lvdss_word_type data_s1;
        lvdss_word_type data_s2;
        lvdss_word_type data_s3;
        logic pclk_level;
        logic fill_valid;
        lvdss_word_type fill_data;
        logic dropped;
        lvdss_word_type hs_data;
        logic hs_req;
        logic ack_s1;
        logic ack_s2;
    } lvdss_sys_type;

    // state of the bit clock domain
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic ack;
        logic running;
        lvdss_slot_type slot;
        lvdss_word_type word;
        logic [LANES-1:0][SLICE_W-1:0] shreg;
        logic [LANES-1:0] lane_p;
        logic [LANES-1:0] lane_n;
        logic clk_p;
        logic clk_n;
        logic drv_en;
    } lvdss_link_type;

    // 7-bit slice of a word for one lane
    function automatic lvdss_slice_type lvdss_slice(
        input lvdss_word_type w,
        input int unsigned lane
    );
        return w[lane*SLICE_W +: SLICE_W];
    endfunction : lvdss_slice

endpackage : lvdss_pkg

// file: src/lvdss_stream_if.sv
`timescale 1ns/1ps
interface lvdss_stream_if #(
    parameter int unsigned W = 21
) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;

    // side that offers words
    modport producer (output data, output valid, input ready);
    // side that takes words
    modport consumer (input data, input valid, output ready);
endinterface : lvdss_stream_if

// file: src/lvdss_fifo.sv
`timescale 1ns/1ps
module lvdss_fifo #(
    parameter int unsigned W = 21,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clear_n_in,
    lvdss_stream_if.consumer fill_if,
    lvdss_stream_if.producer drain_if
);
    // depth must be a power of two so the pointers wrap
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic [W-1:0] out_data;
        logic out_valid;
    } lvdss_fifo_state_type;

    lvdss_fifo_state_type q;
    lvdss_fifo_state_type d;
    logic push;
    logic load;

    // handshake ports straight from state
    assign fill_if.ready = (q.cnt != CNT_FULL);
    assign drain_if.data = q.out_data;
    assign drain_if.valid = q.out_valid;

    // write, pop and refill of the registered head
    always_comb begin
        d = q;
        push = fill_if.valid && (q.cnt != CNT_FULL);
        load = 1'b0;
        if (drain_if.ready && q.out_valid) begin
            d.out_valid = 1'b0;
        end
        if (!d.out_valid && (q.cnt != '0)) begin
            d.out_data = q.mem[q.rd];
            d.out_valid = 1'b1;
            d.rd = q.rd + 1'b1;
            load = 1'b1;
        end
        if (push) begin
            d.mem[q.wr] = fill_if.data;
            d.wr = q.wr + 1'b1;
        end
        if (push && !load) begin
            d.cnt = q.cnt + 1'b1;
        end else if (!push && load) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    // shutdown clears asynchronously, reset synchronously
    always_ff @(posedge clk_in or negedge clear_n_in) begin
        if (!clear_n_in) begin
            q <= '0;
        end else if (reset_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : lvdss_fifo

// file: src/lvdss_serializer.sv
// Functional notes
// [RULE1] three 7-bit parallel-load shift registers carry 21 bits on 3 lanes.
// [RULE2] all 21 data inputs are captured on each pixel clock falling edge; the code drops the word instead while the fifo holds it off.
// [RULE3] a 7x bit clock shifts each 7-bit slice out within one pixel period.
// [RULE4] a forwarded clock at the pixel rate goes out on a fourth lane.
// [RULE5] while shutdown is low, sequencing stops and all drivers are off.
// [RULE6] a low shutdown level asynchronously clears every register to zero.
// [RULE7] the controller keeps the pixel clock between 31 and 68 MHz.
// [RULE8] bit 0 of each lane aligns with the forwarded clock rising edge.
// [RULE9] bits 0-6, 7-13 and 14-20 go to lanes 0, 1 and 2, lsb first.
`timescale 1ns/1ps
module lvdss_serializer (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic power_down_clear_n_in,
    input wire logic input_pixel_clock_in,
    input wire logic [lvdss_pkg::DATA_W-1:0] parallel_data_in,
    input wire logic link_bit_clk_in,
    output logic [lvdss_pkg::LANES-1:0] lane_p_out,
    output logic [lvdss_pkg::LANES-1:0] lane_n_out,
    output logic forwarded_link_clock_p_out,
    output logic forwarded_link_clock_n_out,
    output logic driver_enable_out,
    output logic frame_dropped_out
);
    lvdss_pkg::lvdss_sys_type q;
    lvdss_pkg::lvdss_sys_type d;
    lvdss_pkg::lvdss_link_type l_q;
    lvdss_pkg::lvdss_link_type l_d;

    logic pclk_fall;
    logic pclk_rise;
    logic hs_busy;

    lvdss_stream_if #(.W(lvdss_pkg::DATA_W)) fill_if ();
    lvdss_stream_if #(.W(lvdss_pkg::DATA_W)) drain_if ();

    // elastic store between pixel capture and the link handshake
    lvdss_fifo #(
        .W(lvdss_pkg::DATA_W),
        .DEPTH(lvdss_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .clear_n_in(power_down_clear_n_in),
        .fill_if(fill_if.consumer),
        .drain_if(drain_if.producer)
    );

    // captured word offered to the fifo
    assign fill_if.data = q.fill_data;
    assign fill_if.valid = q.fill_valid;

    // a word in flight to the link blocks the next one
    assign hs_busy = (q.hs_req != q.ack_s2);
    assign drain_if.ready = !hs_busy;

    // pixel clock edges once stages two and three agree
    assign pclk_fall = q.pclk_level
        && !q.pclk_sync[lvdss_pkg::SYNC_MID]
        && !q.pclk_sync[lvdss_pkg::SYNC_LAST];
    assign pclk_rise = !q.pclk_level
        && q.pclk_sync[lvdss_pkg::SYNC_MID]
        && q.pclk_sync[lvdss_pkg::SYNC_LAST];

    // system domain: pin sync, capture, handshake source
    always_comb begin
        d = q;
        d.pclk_sync = {q.pclk_sync[lvdss_pkg::SYNC_STAGES-2:0],
                       input_pixel_clock_in};
        // data delayed to match the clock synchroniser
        d.data_s1 = parallel_data_in;
        d.data_s2 = q.data_s1;
        d.data_s3 = q.data_s2;
        if (pclk_fall) begin
            d.pclk_level = 1'b0;
        end else if (pclk_rise) begin
            d.pclk_level = 1'b1;
        end
        if (q.fill_valid && fill_if.ready) begin
            d.fill_valid = 1'b0;
        end
        // capture on the falling edge, drop if the fifo holds us off
        if (pclk_fall) begin // RULE2
            if (d.fill_valid) begin
                d.dropped = 1'b1;
            end else begin
                d.fill_data = q.data_s3; // RULE2
                d.fill_valid = 1'b1;
            end
        end
        // hand a word to the link domain by toggling the request
        if (drain_if.valid && !hs_busy) begin
            d.hs_data = drain_if.data;
            d.hs_req = ~q.hs_req;
        end
        // acknowledge toggle back from the link domain
        d.ack_s1 = l_q.ack;
        d.ack_s2 = q.ack_s1;
    end

    // system domain register, shutdown clears at once
    always_ff @(posedge clk_in or negedge power_down_clear_n_in) begin
        if (!power_down_clear_n_in) begin
            q <= '0; // RULE6
        end else if (reset_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // link domain: slot count, slice load, shift, line drive
    always_comb begin
        logic frame_end;
        logic bit_val;
        lvdss_pkg::lvdss_slice_type slice;
        frame_end = 1'b0;
        bit_val = 1'b0;
        slice = '0;
        l_d = l_q;
        l_d.rst_s1 = reset_in;
        l_d.rst_s2 = l_q.rst_s1;
        l_d.req_s1 = q.hs_req;
        l_d.req_s2 = l_q.req_s1;
        // slice boundary after slot 6, or any slot while idle
        frame_end = (l_q.slot == lvdss_pkg::SLOT_LAST) || !l_q.running;
        if (frame_end) begin
            l_d.slot = lvdss_pkg::SLOT_FIRST; // RULE3
            // take a new word if one waits, else repeat the last
            if (l_q.req_s2 != l_q.ack) begin
                l_d.word = q.hs_data;
                l_d.ack = ~l_q.ack;
                l_d.running = 1'b1;
            end
        end else begin
            l_d.slot = l_q.slot + 1'b1; // RULE3
        end
        for (int unsigned k = 0; k < lvdss_pkg::LANES; k++) begin
            if (frame_end) begin
                // parallel load, bit 0 goes out with the clock rise
                slice = lvdss_pkg::lvdss_slice(l_d.word, k); // RULE9
                bit_val = slice[0]; // RULE8
                l_d.shreg[k] = slice >> 1; // RULE1
            end else begin
                bit_val = l_q.shreg[k][0];
                l_d.shreg[k] = l_q.shreg[k] >> 1; // RULE1
            end
            l_d.lane_p[k] = bit_val && l_d.running;
            l_d.lane_n[k] = !bit_val && l_d.running;
        end
        // forwarded clock: high for slots 0-3, one period per frame
        l_d.clk_p = lvdss_pkg::FCLK_PATTERN[l_d.slot] && l_d.running; // RULE4
        l_d.clk_n = !lvdss_pkg::FCLK_PATTERN[l_d.slot] && l_d.running;
        l_d.drv_en = l_d.running; // RULE5
        // synchronised reset returns the link to idle
        if (l_q.rst_s2) begin
            l_d = '0;
            l_d.rst_s1 = reset_in;
            l_d.rst_s2 = l_q.rst_s1;
            l_d.req_s1 = q.hs_req;
        end
    end

    // link domain register on the bit clock
    always_ff @(posedge link_bit_clk_in or negedge power_down_clear_n_in)
    begin
        if (!power_down_clear_n_in) begin
            l_q <= '0; // RULE5 RULE6
        end else begin
            l_q <= l_d;
        end
    end

    // outputs straight from flip-flops
    assign lane_p_out = l_q.lane_p;
    assign lane_n_out = l_q.lane_n;
    assign forwarded_link_clock_p_out = l_q.clk_p;
    assign forwarded_link_clock_n_out = l_q.clk_n;
    assign driver_enable_out = l_q.drv_en;
    assign frame_dropped_out = q.dropped;
endmodule : lvdss_serializer

// file: test/lvdss_monitor.sv
`timescale 1ns/1ps
// protocol checker on the serializer pins
module lvdss_monitor (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic power_down_clear_n_in,
    input wire logic link_bit_clk_in,
    input wire logic [lvdss_pkg::LANES-1:0] lane_p_out,
    input wire logic [lvdss_pkg::LANES-1:0] lane_n_out,
    input wire logic forwarded_link_clock_p_out,
    input wire logic forwarded_link_clock_n_out,
    input wire logic driver_enable_out,
    input wire logic frame_dropped_out
);
    logic off;
    // link checks pause in reset or shutdown
    assign off = reset_in || !power_down_clear_n_in;

    a_off_lanes_zero: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !power_down_clear_n_in |-> lane_p_out == 3'h0 && lane_n_out == 3'h0
        && !forwarded_link_clock_p_out && !forwarded_link_clock_n_out)
        else $error("lanes driven in shutdown");
    a_off_clears_state: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !power_down_clear_n_in |-> !driver_enable_out && !frame_dropped_out)
        else $error("state kept in shutdown");
    a_lane_pair_inverse: assert property (
        @(posedge link_bit_clk_in) disable iff (off)
        driver_enable_out |-> lane_n_out == ~lane_p_out)
        else $error("lane pair not complementary");
    a_fclk_pair_inverse: assert property (
        @(posedge link_bit_clk_in) disable iff (off)
        driver_enable_out |->
        forwarded_link_clock_n_out == !forwarded_link_clock_p_out)
        else $error("clock pair not complementary");
    a_fclk_seven_slots: assert property (
        @(posedge link_bit_clk_in) disable iff (off)
        $rose(forwarded_link_clock_p_out) |=> forwarded_link_clock_p_out [*3]
        ##1 !forwarded_link_clock_p_out [*3] ##1 forwarded_link_clock_p_out)
        else $error("forwarded clock not 4 high 3 low");
    a_idle_lanes_zero: assert property (
        @(posedge link_bit_clk_in) disable iff (off)
        !driver_enable_out |-> lane_p_out == 3'h0
        && !forwarded_link_clock_p_out)
        else $error("lanes active while drivers off");
    a_enable_at_slot0: assert property (
        @(posedge link_bit_clk_in) disable iff (off)
        $rose(driver_enable_out) |-> $rose(forwarded_link_clock_p_out))
        else $error("first frame not at clock rise");
    a_enable_stays_on: assert property (
        @(posedge link_bit_clk_in) disable iff (off)
        driver_enable_out |=> driver_enable_out)
        else $error("link stopped while running");
endmodule : lvdss_monitor

bind lvdss_serializer lvdss_monitor MON (.*);

// file: test/lvdss_rx_model.sv
`timescale 1ns/1ps
// receiver at the far end, samples mid-bit
module lvdss_rx_model (
    input wire logic bit_clk_in,
    input wire logic en_in,
    input wire logic [lvdss_pkg::LANES-1:0] lane_p_in,
    input wire logic [lvdss_pkg::LANES-1:0] lane_n_in,
    input wire logic fclk_p_in,
    input wire logic fclk_n_in,
    output lvdss_pkg::lvdss_word_type word_out,
    output int count_out,
    output int pair_err_out
);
    lvdss_pkg::lvdss_word_type acc;
    logic fclk_q = 1'b0;
    int slot = 7;
    initial begin
        count_out = 0;
        pair_err_out = 0;
        word_out = 21'h0;
    end
    // frame starts where the forwarded clock rises
    always @(negedge bit_clk_in) begin
        if (en_in && (lane_n_in !== ~lane_p_in || fclk_n_in !== ~fclk_p_in))
            pair_err_out <= pair_err_out + 1;
        if (fclk_p_in === 1'b1 && fclk_q === 1'b0) slot = 0;
        if (!en_in) slot = 7;
        if (slot < 7) begin
            for (int k = 0; k < 3; k++) acc[k*7+slot] = lane_p_in[k];
            slot = slot + 1;
            if (slot == 7) begin
                word_out <= acc;
                count_out <= count_out + 1;
            end
        end
        fclk_q <= fclk_p_in;
    end
endmodule : lvdss_rx_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic reset_in = 1'b1;
    logic pdcn = 1'b1;
    logic pix = 1'b0;
    lvdss_pkg::lvdss_word_type pdata = 21'h0;
    logic [2:0] lane_p;
    logic [2:0] lane_n;
    logic fclk_p, fclk_n, drv_en, dropped;
    lvdss_pkg::lvdss_word_type rx_word;
    lvdss_pkg::lvdss_word_type rx_q[$];
    int rx_count, pair_err;
    int errors = 0;
    int n_tests = 0;
    lvdss_pkg::lvdss_word_type words[5] = '{21'h000001, 21'h100000,
        21'h155555, 21'h0AAAAA, 21'h1FFFFF};
    // pixel half period in system clocks: 15 ns, 33.3 MHz
    localparam int PIX_HALF = 3;

    always #2.5 clk_in = ~clk_in;
    always #16 link_clk = ~link_clk;

    lvdss_serializer DUT (.clk_in(clk_in), .reset_in(reset_in),
        .power_down_clear_n_in(pdcn), .input_pixel_clock_in(pix),
        .parallel_data_in(pdata), .link_bit_clk_in(link_clk),
        .lane_p_out(lane_p), .lane_n_out(lane_n),
        .forwarded_link_clock_p_out(fclk_p),
        .forwarded_link_clock_n_out(fclk_n),
        .driver_enable_out(drv_en), .frame_dropped_out(dropped));
    lvdss_rx_model RX (.bit_clk_in(link_clk), .en_in(drv_en),
        .lane_p_in(lane_p), .lane_n_in(lane_n), .fclk_p_in(fclk_p),
        .fclk_n_in(fclk_n), .word_out(rx_word), .count_out(rx_count),
        .pair_err_out(pair_err));

    // log every decoded frame
    always @(rx_count) if (rx_count > 0) rx_q.push_back(rx_word);

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task automatic check(input string what,
        input lvdss_pkg::lvdss_word_type exp, got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one pixel period, decoy at the rise, real word before the fall
    task automatic send(input lvdss_pkg::lvdss_word_type w, input int half);
        pdata = ~w;
        pix = 1'b1;
        step(1);
        pdata = w;
        step(half - 1);
        pix = 1'b0;
        step(half);
    endtask : send
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    // words in order, retransmitted repeats folded
    task automatic check_rx(input int from, input int n);
        lvdss_pkg::lvdss_word_type u[$];
        foreach (rx_q[i]) if (u.size() == 0 || u[$] !== rx_q[i])
            u.push_back(rx_q[i]);
        check("frames", 21'(n), 21'(u.size()));
        for (int i = 0; i < n && i < u.size(); i++)
            check("word", words[from+i], u[i]);
    endtask : check_rx

    task automatic t_stream();
        rx_q.delete();
        for (int i = 0; i < 5; i++) send(words[i], PIX_HALF);
        step(300);
        check_rx(0, 5);
        check("pairs", 21'h0, 21'(pair_err));
    endtask : t_stream
    // pixel rate above link rate fills the fifo
    task automatic t_overflow();
        int j;
        rx_q.delete();
        check("drop idle", 21'h0, 21'(dropped));
        for (int i = 1; i <= 30; i++) send(21'(i), PIX_HALF);
        check("drop set", 21'h1, 21'(dropped));
        // skip retransmits of the previous stream's last word
        j = 0;
        while (j < rx_q.size() - 1 && rx_q[j] === words[4]) j++;
        check("first", 21'h1, rx_q[j]);
    endtask : t_overflow
    // shutdown during drain, then a clean restart
    task automatic t_shutdown();
        int seen;
        pdcn = 1'b0;
        step(20);
        seen = rx_count;
        check("lanes", 21'h0, 21'({lane_p, lane_n, fclk_p}));
        check("state", 21'h0, 21'({drv_en, dropped}));
        step(100);
        check("frames off", 21'(seen), 21'(rx_count));
        pdcn = 1'b1;
        step(2);
        rx_q.delete();
        send(words[2], PIX_HALF);
        step(160);
        check_rx(2, 1);
    endtask : t_shutdown

    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge link_clk);
        step(1);
        reset_in = 1'b0;
        step(2);
        check("idle", 21'h0, 21'({drv_en, lane_p, fclk_p}));
        t_stream();
        t_overflow();
        t_shutdown();
        print_verdict();
    end
endmodule : testbench
